// ### core/rssl_top.sv
// Safety stop logic driving the protective and emergency stop outputs.
// Behaviour
// (R1) Curtain interrupted forces protective stop low.
// (R2) Any field not clear blocks robot start.
// (R3) Stop generated regardless of robot mode.
// (R4) Manual reset: low-high-low, high 50 ms..5 s.
// (R5) Valid reset with fields clear permits one start.
// (R6) Manual mode always uses reset validation.
// (R7) Automated mode: scanner interrupted forces stop.
// (R8) Automated mode: never release while scanner interrupted.
// (R9) Pressed emergency button drops emergency output.
// (R10) Emergency stop honoured always, no preconditions.
// (R11) Emergency button evaluated here, not by controller.
// (R12) Safe state holds both outputs low.
// (R13) Reset recognised on button release edge.
// (R14) Emergency output rises only after valid reset.
// (R15) Automated mode releases when both fields clear.
// (R16) Discard out-of-window or field-blocked reset pulses.
// (R17) Emergency stop overrides protective release.
`timescale 1ns/1ns
`default_nettype none
module rssl_top #(
  // Bounds of the reset high phase in clock cycles.
  parameter int unsigned MIN_HIGH_CYC = rssl_pkg::PULSE_MIN_CYC,
  parameter int unsigned MAX_HIGH_CYC = rssl_pkg::PULSE_MAX_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Configuration strap: high selects automated reset of the protective stop.
  input  wire logic auto_reset_mode,
  // Field inputs, high when the field is clear.
  input  wire logic curtain_clear,
  input  wire logic scanner_clear,
  // Emergency button contact, high while not pressed.
  input  wire logic estop_released,
  // Reset button, high while pressed.
  input  wire logic reset_button,
  // Safe outputs, high means released.
  output logic      protective_stop_n,
  output logic      emergency_stop_n,
  // One-cycle pulse: a valid reset was accepted.
  output logic      reset_accepted
);
  rssl_pin_if pins ();

  // Cycle bounds for the reset high phase.
  localparam logic [rssl_pkg::CNT_W-1:0] MIN_CYC =
    rssl_pkg::CNT_W'(MIN_HIGH_CYC);
  localparam logic [rssl_pkg::CNT_W-1:0] MAX_CYC =
    rssl_pkg::CNT_W'(MAX_HIGH_CYC);
  // Low cycles to see after reset before the button level can be trusted.
  localparam logic [rssl_pkg::CNT_W-1:0] SETTLE_CYC =
    rssl_pkg::CNT_W'(rssl_pkg::SYNC_STAGES + 1);
  // The cycle that enters the high phase already counts as one.
  localparam logic [rssl_pkg::CNT_W-1:0] ONE_CYC = rssl_pkg::CNT_W'(1);

  logic                     fields_clear;
  logic                     curtain_ok;
  logic                     scanner_ok;
  logic                     estop_ok;
  logic                     button;
  logic                     button_q;
  logic                     fall;
  logic                     valid_pulse;
  logic                     mode_q;
  logic                     mode_seen_q;
  logic [rssl_pkg::CNT_W-1:0] cnt_q;
  logic                     blocked_q;
  rssl_pkg::rssl_pulse_e    st_q;
  logic                     estop_out_q;
  logic                     prot_out_q;
  logic                     accept_q;

  // Pins enter through the three-stage synchroniser.
  rssl_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pins_raw ({reset_button, estop_released, scanner_clear, curtain_clear}),
    .idle_val (4'h0),
    .out      (pins)
  );

  assign curtain_ok   = pins.level[rssl_pkg::PIN_CURTAIN];
  assign scanner_ok   = pins.level[rssl_pkg::PIN_SCANNER];
  assign estop_ok     = pins.level[rssl_pkg::PIN_ESTOP];
  assign button       = pins.level[rssl_pkg::PIN_RESET];
  assign fields_clear = curtain_ok & scanner_ok;
  assign fall         = button_q & ~button; // R13

  // Mode strap is caught once after reset release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q      <= 1'b0;
      mode_seen_q <= 1'b0;
    end else if (!mode_seen_q) begin
      mode_q      <= auto_reset_mode;
      mode_seen_q <= 1'b1;
    end
  end

  // Previous button level for edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      button_q <= 1'b0;
    end else begin
      button_q <= button;
    end
  end

  // Pulse validator: low, then high for a timed window, then low again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= rssl_pkg::RSSL_WAIT_LOW;
      cnt_q     <= '0;
      blocked_q <= 1'b0;
    end else begin
      case (st_q)
        rssl_pkg::RSSL_WAIT_LOW: begin
          // A button held at power-up must be released first; the level
          // reads low until the synchroniser has filled, so wait that out.
          if (button) begin
            cnt_q <= '0; // R16
          end else if (cnt_q >= SETTLE_CYC) begin
            st_q <= rssl_pkg::RSSL_IDLE_LOW;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rssl_pkg::RSSL_IDLE_LOW: begin
          if (button) begin // R4
            st_q      <= rssl_pkg::RSSL_HIGH;
            cnt_q     <= ONE_CYC;
            blocked_q <= ~fields_clear; // R16
          end
        end
        rssl_pkg::RSSL_HIGH: begin
          if (!fields_clear) begin
            blocked_q <= 1'b1; // R16
          end
          if (!button) begin
            st_q <= rssl_pkg::RSSL_IDLE_LOW;
          end else if (cnt_q >= MAX_CYC) begin
            st_q <= rssl_pkg::RSSL_TOO_LONG; // R16
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rssl_pkg::RSSL_TOO_LONG: begin
          if (!button) begin
            st_q <= rssl_pkg::RSSL_IDLE_LOW;
          end
        end
        default: begin
          st_q <= rssl_pkg::RSSL_WAIT_LOW;
        end
      endcase
    end
  end

  // Valid on the release edge with the high phase inside the window.
  assign valid_pulse = (st_q == rssl_pkg::RSSL_HIGH) && fall &&
                       (cnt_q >= MIN_CYC) && (cnt_q <= MAX_CYC) && // R4
                       !blocked_q && fields_clear; // R16

  // Emergency output: drops at once, rises only on a valid reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      estop_out_q <= 1'b0; // R12
    end else if (!estop_ok) begin
      estop_out_q <= 1'b0; // R9 R10 R11
    end else if (!estop_out_q && valid_pulse) begin
      estop_out_q <= 1'b1; // R14
    end
  end

  // Protective output in both reset variants; a reset that also clears the
  // emergency stop releases both outputs on the same pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_out_q <= 1'b0; // R12
    end else if (!curtain_ok) begin
      prot_out_q <= 1'b0; // R1 R3
    end else if (!scanner_ok) begin
      prot_out_q <= 1'b0; // R2 R7 R8
    end else if (!mode_seen_q) begin
      prot_out_q <= 1'b0;
    end else if (mode_q) begin
      prot_out_q <= estop_out_q; // R15 R17
    end else if (!prot_out_q && valid_pulse && estop_ok) begin
      prot_out_q <= 1'b1; // R5 R6 R17
    end
  end

  // One-cycle marker of an accepted reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= valid_pulse; // R5
    end
  end

  // Gate the protective output with the emergency state as well.
  assign protective_stop_n = prot_out_q & estop_out_q & fields_clear; // R17
  assign emergency_stop_n  = estop_out_q;
  assign reset_accepted    = accept_q;
endmodule : rssl_top
`default_nettype wire

// ### core/rssl_pkg.sv
// Package with timing counts and constants for the robot safety stop logic.
package rssl_pkg;
  // Clock rate in hertz.
  localparam int unsigned CLK_HZ = 25000000;
  // Shortest accepted high phase of the reset button, in milliseconds.
  localparam int unsigned PULSE_MIN_MS = 50;
  // Longest accepted high phase of the reset button, in milliseconds.
  localparam int unsigned PULSE_MAX_MS = 5000;
  // Cycle counts derived from the times; both use whole cycles per millisecond, rounded down.
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_MS * (CLK_HZ / 1000) + 0) ;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000);
  // Width of the pulse timer.
  localparam int unsigned CNT_W = 28;
  // Number of synchroniser stages for pin inputs.
  localparam int unsigned SYNC_STAGES = 3;
  // Number of pin inputs that pass the synchroniser.
  localparam int unsigned N_PINS = 4;
  // Bit positions of the pins in the synchroniser vector.
  localparam int unsigned PIN_CURTAIN = 0;
  localparam int unsigned PIN_SCANNER = 1;
  localparam int unsigned PIN_ESTOP   = 2;
  localparam int unsigned PIN_RESET   = 3;
  // States of the reset pulse validator.
  typedef enum logic [1:0] {
    RSSL_WAIT_LOW,
    RSSL_IDLE_LOW,
    RSSL_HIGH,
    RSSL_TOO_LONG
  } rssl_pulse_e;
endpackage : rssl_pkg

// ### core/rssl_pin_if.sv
// Interface carrying the synchronised pin levels between modules.
`timescale 1ns/1ns
`default_nettype none
interface rssl_pin_if;
  // Stable, synchronised levels of the pin inputs.
  logic [rssl_pkg::N_PINS-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : rssl_pin_if
`default_nettype wire

// ### core/rssl_sync.sv
// Three-stage synchroniser that passes a pin change once two stages agree.
`timescale 1ns/1ns
`default_nettype none
module rssl_sync (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Raw pin levels and their safe idle values.
  input  wire logic [rssl_pkg::N_PINS-1:0] pins_raw,
  input  wire logic [rssl_pkg::N_PINS-1:0] idle_val,
  // Synchronised levels.
  rssl_pin_if.src                          out
);
  genvar g;
  // One synchroniser chain per pin.
  generate
    for (g = 0; g < rssl_pkg::N_PINS; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // Stages and the held level reset to zero, which reads as a stop.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pins_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign out.level[g] = lvl_q;
    end
  endgenerate
  // The idle values are unused because every stage resets to zero.
  logic unused_idle;
  assign unused_idle = ^idle_val;
endmodule : rssl_sync
`default_nettype wire

// ### verification/rssl_monitor.sv
// Checker of the stop outputs against the field and button pins.
`timescale 1ns/1ns
`default_nettype none
module rssl_monitor #(
  // Bounds of the reset high phase in clock cycles.
  parameter int unsigned MIN_CYC = rssl_pkg::PULSE_MIN_CYC,
  parameter int unsigned MAX_CYC = rssl_pkg::PULSE_MAX_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins.
  input wire logic auto_reset_mode,
  input wire logic curtain_clear,
  input wire logic scanner_clear,
  input wire logic estop_released,
  input wire logic reset_button,
  // Outputs.
  input wire logic protective_stop_n,
  input wire logic emergency_stop_n,
  input wire logic reset_accepted
);
  logic [rssl_pkg::CNT_W-1:0] hi_q;
  logic [rssl_pkg::CNT_W-1:0] len_q;
  // Measures the high phase of the reset button, kept on release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q  <= '0;
      len_q <= '0;
    end else begin
      hi_q <= reset_button ? hi_q + 1'b1 : '0;
      if (!reset_button && hi_q != '0) len_q <= hi_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence curtain_out;
    !curtain_clear [*6];
  endsequence
  sequence field_out;
    (!curtain_clear || !scanner_clear) [*6];
  endsequence
  sequence estop_out;
    !estop_released [*6];
  endsequence
  chk_curtain_stop: assert property (curtain_out |-> !protective_stop_n)
    else $error("Curtain blocked but stop released.");
  chk_field_block: assert property (field_out |-> !protective_stop_n)
    else $error("Field blocked but stop released.");
  chk_scan_auto: assert property (
    (auto_reset_mode && !scanner_clear) [*6] |-> !protective_stop_n)
    else $error("Scanner blocked but stop released.");
  chk_estop_drop: assert property (estop_out |-> !emergency_stop_n)
    else $error("Button pressed but emergency released.");
  chk_estop_first: assert property (!emergency_stop_n |-> !protective_stop_n)
    else $error("Protective released during emergency.");
  chk_estop_rise: assert property ($rose(emergency_stop_n) |-> reset_accepted)
    else $error("Emergency released without reset.");
  chk_manual_rise: assert property (
    !auto_reset_mode && $rose(protective_stop_n) |-> reset_accepted)
    else $error("Manual release without reset.");
  chk_pulse_once: assert property (reset_accepted |=> !reset_accepted)
    else $error("Reset pulse longer than one cycle.");
  chk_pulse_window: assert property (
    reset_accepted |-> len_q >= MIN_CYC && len_q <= MAX_CYC)
    else $error("Reset taken outside the time window.");
  chk_auto_release: assert property (
    (auto_reset_mode && emergency_stop_n && curtain_clear && scanner_clear)
    [*8] |-> protective_stop_n)
    else $error("Automated release missing.");
endmodule // rssl_monitor
bind rssl_top rssl_monitor #(.MIN_CYC(MIN_HIGH_CYC), .MAX_CYC(MAX_HIGH_CYC))
  chk (.clk(clk), .rst_n(rst_n),
  .auto_reset_mode(auto_reset_mode), .curtain_clear(curtain_clear),
  .scanner_clear(scanner_clear), .estop_released(estop_released),
  .reset_button(reset_button), .protective_stop_n(protective_stop_n),
  .emergency_stop_n(emergency_stop_n), .reset_accepted(reset_accepted));
`default_nettype wire

// ### verification/rssl_robot_model.sv
// Model of the robot controller's safe stop inputs.
`timescale 1ns/1ns
`default_nettype none
module rssl_robot_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Safe stop inputs, high means released.
  input  wire logic protective_stop_n,
  input  wire logic emergency_stop_n,
  // High while the robot may move.
  output logic      run_q
);
  // Moves only with both stops released; it never sees the button.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) run_q <= 1'b0;
    else run_q <= protective_stop_n & emergency_stop_n;
  end
endmodule // rssl_robot_model
`default_nettype wire

// ### verification/robot_safety_stop_logic_bench.sv
// Self-checking bench for the robot safety stop logic.
`timescale 1ns/1ns
`default_nettype none
module robot_safety_stop_logic_bench;
  // Short pulse window so that valid resets fit in the run.
  localparam int unsigned T_MIN = 20;
  localparam int unsigned T_MAX = 150;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic auto_m = 1'b0;
  logic cur = 1'b1;
  logic scn = 1'b1;
  logic est = 1'b1;
  logic btn = 1'b0;
  logic pstop_n, estop_n, acc, run;
  logic exp_e = 1'b0;
  logic exp_p = 1'b0;
  logic [7:0] acc_cnt;
  int bad_count = 0;
  int checks = 0;
  // Clock of 40 ns.
  always #20 clk = ~clk;
  rssl_top #(.MIN_HIGH_CYC(T_MIN), .MAX_HIGH_CYC(T_MAX)) DUT (.clk(clk),
    .rst_n(rst_n), .auto_reset_mode(auto_m),
    .curtain_clear(cur), .scanner_clear(scn), .estop_released(est),
    .reset_button(btn), .protective_stop_n(pstop_n),
    .emergency_stop_n(estop_n), .reset_accepted(acc));
  rssl_robot_model robot (.clk(clk), .rst_n(rst_n),
    .protective_stop_n(pstop_n), .emergency_stop_n(estop_n), .run_q(run));
  // Counts accept markers; an unknown marker poisons the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt <= 8'h00;
    end else begin
      acc_cnt <= acc_cnt + {7'h00, acc};
    end
  end
  // A pulse is taken when its length fits and both fields are clear.
  function automatic logic pulse_ok(input int len, input logic c, s);
    return (len >= T_MIN) && (len <= T_MAX) && c && s;
  endfunction
  // Protective level: fields clear, emergency released, latch or auto mode.
  function automatic logic prot_exp(input logic a, p, e, c, s);
    return (a | p) & e & c & s;
  endfunction
  task automatic cmp(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Sets the pins, pulses the button len cycles, lets it settle, checks.
  task automatic step(input logic c, s, e, input int len);
    logic [7:0] base;
    logic ok;
    ok = pulse_ok(len, c, s);
    @(posedge clk);
    base = acc_cnt;
    cur <= c;
    scn <= s;
    est <= e;
    if (len > 0) begin
      btn <= 1'b1;
      repeat (len) @(posedge clk);
      btn <= 1'b0;
    end
    repeat (10) @(negedge clk);
    if (!(c && s)) begin
      exp_p = 1'b0;
    end else if (ok && e) begin
      exp_p = 1'b1;
    end
    if (!e) begin
      exp_e = 1'b0;
    end else if (ok) begin
      exp_e = 1'b1;
    end
    cmp_cnt(acc_cnt - base, {7'h00, ok});
    cmp(estop_n, exp_e);
    cmp(pstop_n, prot_exp(auto_m, exp_p, exp_e, c, s));
    cmp(run, prot_exp(auto_m, exp_p, exp_e, c, s));
  endtask
  // Both modes, each after a reset with the button held down.
  initial begin
    void'($urandom(204));
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      auto_m <= m[0];
      cur <= 1'b1;
      scn <= 1'b1;
      est <= 1'b1;
      btn <= 1'b1;
      exp_e = 1'b0;
      exp_p = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      btn <= 1'b0;
      repeat (10) @(posedge clk);
      cmp_cnt(acc_cnt, 8'h00);
      step(1'b1, 1'b1, 1'b1, 0);
      step(1'b1, 1'b1, 1'b1, T_MIN - 1);
      step(1'b1, 1'b1, 1'b1, T_MIN);
      step(1'b0, 1'b1, 1'b1, 0);
      step(1'b1, 1'b1, 1'b1, 0);
      step(1'b1, 1'b1, 1'b1, T_MAX + 1);
      step(1'b1, 1'b1, 1'b1, T_MAX);
      step(1'b1, 1'b0, 1'b1, 60);
      step(1'b1, 1'b1, 1'b1, 60);
      step(1'b1, 1'b1, 1'b0, 60);
      step(1'b1, 1'b1, 1'b1, 0);
      step(1'b1, 1'b1, 1'b1, 100);
      repeat (30) begin
        step(1'($urandom_range(1)), 1'($urandom_range(1)),
          1'($urandom_range(1)), $urandom_range(200));
      end
    end
    stop_test();
  end
  // Cuts a hang short; the tests need under 15000 cycles.
  initial begin
    #800000;
    bad_count++;
    stop_test();
  end
endmodule // robot_safety_stop_logic_bench
`default_nettype wire
